// ### src/dram_mode_map.vh
// Purpose: Offsets, field positions, reset values and timing for the mode
//          control register.
// Assumes: Register reached by configuration space word access.
// Notes:   Definitions only.
`ifndef DRAM_MODE_MAP_VH
`define DRAM_MODE_MAP_VH

// =====================================================================
// Register map
`define MODE_CTRL_OFFSET 8'h70
`define MODE_CTRL_RESET 32'h00000081
`define MODE_CTRL_WR_MASK 32'h203093FF

// =====================================================================
// Field positions
`define FLD_REV_HI 31
`define FLD_REV_LO 30
`define FLD_INIT_DONE 29
`define FLD_CHANNEL_COUNT_HI 23
`define FLD_CHANNEL_COUNT_LO 22
`define FLD_DIM_HI 21
`define FLD_DIM_LO 20
`define FLD_RAS_LOCK 15
`define FLD_ADDR_TRI 12
`define FLD_RMS_HI 9
`define FLD_RMS_LO 7
`define FLD_SMS_HI 6
`define FLD_SMS_LO 4

// =====================================================================
// Encodings
`define CHANNEL_COUNT_ONE 2'h0
`define DIM_NO_ECC 2'h0
`define DIM_ECC 2'h1
`define RMS_OFF 3'h0
`define RMS_15US6 3'h1
`define RMS_7US8 3'h2
`define RMS_FAST 3'h7
`define SMS_POST_RESET 3'h0

// =====================================================================
// Timing
`define CLK_PERIOD_PS 40000
`define REF_15US6_PS 15600000
`define REF_7US8_PS 7800000
`define REF_FAST_CLKS 20'h00040

`endif

// ### src/dram_mode_ctrl.v
// Purpose: Mode control register of the DDR controller and the refresh,
//          ECC, auto-precharge and pin-tristate behaviour it governs.
// Assumes: Config bus accesses are single-cycle strobes on core_clk_i.
// Notes:   Write mask keeps read-only and reserved bits stable.
`timescale 1ns/1ns
`include "dram_mode_map.vh"

// What this block does
// - Two-bit read-only format revision; writes ignored.
// - Refresh held off until init_complete is written to one.
// - Refresh runs only when init_complete and refresh_rate_select allow.
// - Read-only channel count reports exactly one channel.
// - Mode 00: no read-merge-write, check receivers off, check outputs hiZ.
// - RAS lock-out set: auto-precharge issued without row-active check.
// - RAS lock-out set: no activate to auto-precharged bank before tRP.
// - RAS lock-out clear: auto-precharge only once tRAS is met.
// - Tristate enable: float address, command, selects only with all CKE low.
// - No fast chip-select toward a row whose clock enable is low.
// - Row clock enables drop on idle timer and/or max row count.
// - Refresh rates: off, 15.6 us, 7.8 us, or every 64 clocks.
// - Clock enables low after reset until special mode written nonzero.
module dram_mode_ctrl #(
    parameter ROWS = 4,
    parameter BANKS = 4,
    parameter TRAS_CLKS = 6,
    parameter TRP_CLKS = 3,
    parameter IDLE_CLKS = 16,
    parameter MAX_ROWS_ON = 4,
    parameter [1:0] FORMAT_REV = 2'h0
)(
    input wire core_clk_i,
    input wire reset_i,
    input wire cfg_wr_i,
    input wire cfg_rd_i,
    input wire [7:0] cfg_addr_i,
    input wire [31:0] cfg_wdata_i,
    output reg [31:0] cfg_rdata_o,
    input wire act_req_i,
    input wire [1:0] act_bank_i,
    input wire ap_req_i,
    input wire [1:0] ap_bank_i,
    input wire partial_wr_i,
    input wire fast_cs_req_i,
    input wire [1:0] fast_cs_row_i,
    input wire row_busy_i,
    output wire act_ok_o,
    output wire ap_ok_o,
    output wire rmw_en_o,
    output wire fast_cs_ok_o,
    output reg refresh_req_o,
    output wire ecc_rx_en_o,
    output wire ecc_oe_o,
    output wire addr_oe_o,
    output reg [ROWS-1:0] cke_o
);

    localparam integer REF_15US6_CLKS = `REF_15US6_PS / `CLK_PERIOD_PS;
    localparam integer REF_7US8_CLKS = `REF_7US8_PS / `CLK_PERIOD_PS;

    // =================================================================
    // Register
    reg [31:0] mode_ff;
    wire [31:0] nxt_mode;
    wire hit;
    wire [31:0] rd_view;

    assign hit = (cfg_addr_i == `MODE_CTRL_OFFSET);
    // Only writable bits pass; revision, count and reserved stay fixed.
    assign nxt_mode = (mode_ff & ~`MODE_CTRL_WR_MASK) |
                      (cfg_wdata_i & `MODE_CTRL_WR_MASK);

    always @(posedge core_clk_i)
    begin
        if (reset_i)
            mode_ff <= `MODE_CTRL_RESET;
        else if (cfg_wr_i && hit)
            mode_ff <= nxt_mode;
    end

    assign rd_view = {FORMAT_REV, mode_ff[29:24], `CHANNEL_COUNT_ONE,
                      mode_ff[21:0]};

    // Reads of other offsets return zero so no stale word leaks out.
    always @(posedge core_clk_i)
    begin
        if (reset_i)
            cfg_rdata_o <= 32'h00000000;
        else if (cfg_rd_i)
            cfg_rdata_o <= hit ? rd_view : 32'h00000000;
    end

    wire init_done = mode_ff[`FLD_INIT_DONE];
    wire ras_lock = mode_ff[`FLD_RAS_LOCK];
    wire addr_tri = mode_ff[`FLD_ADDR_TRI];
    wire [1:0] dim = mode_ff[`FLD_DIM_HI:`FLD_DIM_LO];
    wire [2:0] refresh_rate_select = mode_ff[`FLD_RMS_HI:`FLD_RMS_LO];
    wire [2:0] special_mode_select = mode_ff[`FLD_SMS_HI:`FLD_SMS_LO];

    // =================================================================
    // Refresh timer
    reg [19:0] ref_cnt_ff;
    reg [2:0] rms_last_ff;
    reg [19:0] ref_limit;

    // Reserved rate codes leave the limit at zero, which parks the timer.
    always @*
    begin
        case (refresh_rate_select)
            `RMS_15US6: ref_limit = REF_15US6_CLKS[19:0];
            `RMS_7US8: ref_limit = REF_7US8_CLKS[19:0];
            `RMS_FAST: ref_limit = `REF_FAST_CLKS;
            default: ref_limit = 20'h00000;
        endcase
    end

    wire ref_run = init_done && (ref_limit != 20'h00000);

    // A change of rate restarts the count so tests can align refreshes.
    always @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            ref_cnt_ff <= 20'h00000;
            rms_last_ff <= `RMS_OFF;
            refresh_req_o <= 1'b0;
        end
        else
        begin
            rms_last_ff <= refresh_rate_select;
            refresh_req_o <= 1'b0;
            if (!ref_run || refresh_rate_select != rms_last_ff)
                ref_cnt_ff <= 20'h00000;
            else if (ref_cnt_ff == ref_limit - 20'h00001)
            begin
                ref_cnt_ff <= 20'h00000;
                refresh_req_o <= 1'b1;
            end
            else
                ref_cnt_ff <= ref_cnt_ff + 20'h00001;
        end
    end

    // =================================================================
    // Data integrity
    wire ecc_on = (dim == `DIM_ECC);
    assign rmw_en_o = ecc_on && partial_wr_i;
    assign ecc_rx_en_o = ecc_on;
    assign ecc_oe_o = ecc_on;

    // =================================================================
    // Per-bank row-active and precharge timing
    reg [7:0] tras_ff [0:BANKS-1];
    reg [7:0] trp_ff [0:BANKS-1];
    integer b;

    always @(posedge core_clk_i)
    begin
        for (b = 0; b < BANKS; b = b + 1)
        begin
            if (reset_i)
            begin
                tras_ff[b] <= 8'h00;
                trp_ff[b] <= 8'h00;
            end
            else
            begin
                if (act_req_i && act_ok_o && act_bank_i == b)
                    tras_ff[b] <= TRAS_CLKS[7:0];
                else if (tras_ff[b] != 8'h00)
                    tras_ff[b] <= tras_ff[b] - 8'h01;
                if (ap_req_i && ap_ok_o && ap_bank_i == b)
                    trp_ff[b] <= TRP_CLKS[7:0];
                else if (trp_ff[b] != 8'h00)
                    trp_ff[b] <= trp_ff[b] - 8'h01;
            end
        end
    end

    // Lock-out trusts the memory for tRAS but must then guard tRP itself.
    assign ap_ok_o = ras_lock ||
                     (tras_ff[ap_bank_i] == 8'h00);
    assign act_ok_o = (trp_ff[act_bank_i] == 8'h00);

    // =================================================================
    // Clock enables and pin tristate
    // Busy wakes only MAX_ROWS_ON rows; the rest sleep to save power.
    reg armed_ff;
    reg [7:0] idle_ff;
    wire all_cke_low = (cke_o == {ROWS{1'b0}});

    always @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            armed_ff <= 1'b0;
            idle_ff <= 8'h00;
            cke_o <= {ROWS{1'b0}};
        end
        else
        begin
            if (special_mode_select != `SMS_POST_RESET)
                armed_ff <= 1'b1;
            if (row_busy_i)
                idle_ff <= 8'h00;
            else if (idle_ff != IDLE_CLKS[7:0])
                idle_ff <= idle_ff + 8'h01;
            if (!armed_ff && special_mode_select != `SMS_POST_RESET)
                cke_o <= {ROWS{1'b1}};
            else if (armed_ff && row_busy_i)
                cke_o <= {ROWS{1'b1}} >> (ROWS - MAX_ROWS_ON);
            else if (armed_ff && idle_ff == IDLE_CLKS[7:0])
                cke_o <= {ROWS{1'b0}};
        end
    end

    // Pins float only when every row sleeps, so no command is lost.
    assign fast_cs_ok_o = fast_cs_req_i && cke_o[fast_cs_row_i];
    assign addr_oe_o = !(addr_tri && all_cke_low);

endmodule // dram_mode_ctrl

// ### dv/mem_rows_model.sv
// Purpose: Far-side traffic source for the mode control block.
// Assumes: One channel of memory rows behind the controller.
// Notes:   Busy lags the request by one clock, as a real queue does.
`timescale 1ns/1ns
module mem_rows_model (
    input wire core_clk_i,
    input wire want_i,
    output reg busy_o
);
    initial busy_o = 1'h0;
    always @(posedge core_clk_i)
        busy_o <= want_i;
endmodule // mem_rows_model

// ### dv/dram_mode_chk.sv
// Purpose: Port assertions for the mode control block.
// Assumes: Synchronous active high reset on core_clk_i.
// Notes:   Bound into every instance of the block.
`timescale 1ns/1ns
module dram_mode_chk #(
    parameter ROWS = 4
)(
    input wire core_clk_i,
    input wire reset_i,
    input wire cfg_rd_i,
    input wire [7:0] cfg_addr_i,
    input wire [31:0] cfg_rdata_o,
    input wire partial_wr_i,
    input wire fast_cs_req_i,
    input wire [1:0] fast_cs_row_i,
    input wire rmw_en_o,
    input wire fast_cs_ok_o,
    input wire refresh_req_o,
    input wire ecc_rx_en_o,
    input wire ecc_oe_o,
    input wire addr_oe_o,
    input wire [ROWS-1:0] cke_o
);
    // ====================
    // Properties
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    a_addr_driven: assert property (cke_o != 0 |-> addr_oe_o)
        else $error("Address pins floated with a clock enable high.");
    a_fast_cs_gate:
        assert property (fast_cs_ok_o |-> fast_cs_req_i && cke_o[fast_cs_row_i])
        else $error("Fast select granted to a sleeping row.");
    a_ecc_pair: assert property (ecc_rx_en_o == ecc_oe_o)
        else $error("Check receivers and drivers disagree.");
    a_rmw_gate:
        assert property (rmw_en_o == (partial_wr_i && ecc_oe_o))
        else $error("Merge write outside ECC partial write.");
    a_ref_spacing:
        assert property (refresh_req_o |=> !refresh_req_o [*8])
        else $error("Refresh pulses too close.");
    a_cke_reset: assert property (disable iff (1'h0)
        reset_i |=> cke_o == 0 && !refresh_req_o)
        else $error("Clock enable or refresh active in reset.");
    a_id_fields:
        assert property (cfg_rd_i && cfg_addr_i == 8'h70
        |=> {cfg_rdata_o[31:30], cfg_rdata_o[28:22]} == 9'h000)
        else $error("Read-only fields wrong.");
    a_unmapped_zero:
        assert property (cfg_rd_i && cfg_addr_i != 8'h70 |=> cfg_rdata_o == 0)
        else $error("Unmapped read not zero.");
    cover property (refresh_req_o);
    cover property (rmw_en_o);
    cover property (!addr_oe_o);
endmodule // dram_mode_chk

bind dram_mode_ctrl dram_mode_chk #(.ROWS(ROWS)) u_dram_mode_chk (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .cfg_rd_i(cfg_rd_i),
    .cfg_addr_i(cfg_addr_i), .cfg_rdata_o(cfg_rdata_o),
    .partial_wr_i(partial_wr_i), .fast_cs_req_i(fast_cs_req_i),
    .fast_cs_row_i(fast_cs_row_i), .rmw_en_o(rmw_en_o),
    .fast_cs_ok_o(fast_cs_ok_o), .refresh_req_o(refresh_req_o),
    .ecc_rx_en_o(ecc_rx_en_o), .ecc_oe_o(ecc_oe_o),
    .addr_oe_o(addr_oe_o), .cke_o(cke_o)
);

// ### dv/tb.sv
// Purpose: Self-checking bench for the mode control block.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Refresh spans are measured between two later pulses.
`timescale 1ns/1ns
module tb;
    reg clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, act = 1'h0, ap = 1'h0;
    reg pw = 1'h0, fcs = 1'h0, want = 1'h1;
    reg [7:0] adr = 8'h00;
    reg [31:0] wd = 32'h00000000;
    wire [31:0] rdat;
    wire busy, aok, pok, rmw, fok, refr, erx, eoe, aoe;
    wire [3:0] cke;
    integer fail_count = 0, n_compared = 0, cyc = 0, i, c, s0, s1;
    // ====================
    // Harness
    dram_mode_ctrl u_dram_mode_ctrl (.core_clk_i(clk), .reset_i(rst),
        .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(adr), .cfg_wdata_i(wd),
        .cfg_rdata_o(rdat), .act_req_i(act), .act_bank_i(2'h1),
        .ap_req_i(ap), .ap_bank_i(2'h1), .partial_wr_i(pw),
        .fast_cs_req_i(fcs), .fast_cs_row_i(2'h0), .row_busy_i(busy),
        .act_ok_o(aok), .ap_ok_o(pok), .rmw_en_o(rmw), .fast_cs_ok_o(fok),
        .refresh_req_o(refr), .ecc_rx_en_o(erx), .ecc_oe_o(eoe),
        .addr_oe_o(aoe), .cke_o(cke));
    mem_rows_model u_mem_rows_model (.core_clk_i(clk), .want_i(want),
        .busy_o(busy));
    initial forever #20 clk = ~clk;
    task chk(input [31:0] s, input [31:0] e);
    begin
        n_compared = n_compared + 1;
        if (s !== e)
        begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: saw %h expected %h", $time, s, e);
        end
    end
    endtask
    task stop_test;
    begin
        $display("compared %0d, mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task wrr(input [31:0] d);
    begin
        @(negedge clk);
        wr = 1'h1;
        adr = 8'h70;
        wd = d;
        @(negedge clk);
        wr = 1'h0;
    end
    endtask
    task rdd(input [7:0] a, input [31:0] e);
    begin
        @(negedge clk);
        rd = 1'h1;
        adr = a;
        @(negedge clk);
        rd = 1'h0;
        chk(rdat, e);
    end
    endtask
    // A zero span means that no refresh may occur in the window.
    task gap(input [31:0] e);
    begin
        c = 0;
        s0 = 0;
        s1 = 0;
        for (i = 0; i < 900; i = i + 1)
        begin
            @(negedge clk);
            if (refr === 1'h1)
            begin
                s1 = s0;
                s0 = i;
                c = c + 1;
            end
        end
        chk(e == 0 ? c : s0 - s1, e);
    end
    endtask
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            fail_count = fail_count + 1;
            stop_test;
        end
    end
    initial
    begin
        repeat (2) @(negedge clk);
        rst = 1'h0;
        rdd(8'h70, 32'h00000081);
        rdd(8'h74, 32'h00000000);
        chk({cke, aoe, erx, eoe}, 32'h04);
        wrr(32'hFFFFFFFF);
        @(negedge clk);
        chk({cke, erx, eoe}, 32'h3C);
        rdd(8'h70, 32'h203093FF);
        wrr(32'h00000390);
        gap(32'h0);
        wrr(32'h20000390);
        gap(32'h40);
        wrr(32'h20000110);
        gap(32'hC3);
        wrr(32'h20000090);
        gap(32'h186);
        wrr(32'h20000190);
        gap(32'h0);
        wrr(32'h20000010);
        gap(32'h0);
        pw = 1'h1;
        wrr(32'h20100010);
        chk({erx, eoe, rmw}, 32'h7);
        wrr(32'h20000010);
        chk({erx, eoe, rmw}, 32'h0);
        want = 1'h0;
        fcs = 1'h1;
        wrr(32'h20001010);
        repeat (30) @(negedge clk);
        chk({cke, aoe, fok}, 32'h0);
        want = 1'h1;
        repeat (4) @(negedge clk);
        chk({aoe, fok}, 32'h3);
        act = 1'h1;
        @(negedge clk);
        act = 1'h0;
        chk(pok, 32'h0);
        repeat (8) @(negedge clk);
        chk(pok, 32'h1);
        wrr(32'h20009010);
        act = 1'h1;
        @(negedge clk);
        act = 1'h0;
        chk(pok, 32'h1);
        ap = 1'h1;
        @(negedge clk);
        ap = 1'h0;
        chk(aok, 32'h0);
        repeat (5) @(negedge clk);
        chk(aok, 32'h1);
        stop_test;
    end
endmodule // tb
